// File: hw/osdsc_core.v
// apb register block for scroll control, sync delays and fast blank
// assumes blank and sync inputs come from pins and pixel data from logic
// on core_clk
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "osdsc_defines.vh"

module osdsc_core
#(
  parameter LEAD_CYC = `OSDSC_LEAD_MS * `OSDSC_CLK_MHZ * 1000,
  parameter SCROLL_FIELDS = 16,
  parameter PULSE_W = 8
)
(
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire hsyncIn,
  input wire vsyncIn,
  input wire hBlankIn,
  input wire vBlankIn,
  input wire pixelOn,
  input wire [2:0] pixelRgb,
  input wire serialAttr,
  output reg hsyncOut,
  output reg halfLineFieldPulse,
  output reg [2:0] rgbOut,
  output reg fastBlank,
  output reg underlineEn,
  output reg captionMode,
  output reg scrollAreaEnable,
  output reg [3:0] firstScrollRow,
  output reg busyFlag,
  output wire irq
);

  // ==========================================================
  // helpers

  // delay count in clocks for a field value and a step size
  function [10:0] dlyClks;
    input [6:0] val;
    input [3:0] step;
    begin
      dlyClks = val * step;
    end
  endfunction

  // ==========================================================
  // pin synchronisers

  reg [3:0] sync1_r; // first stage, read by stage two only
  reg [3:0] sync2_r;
  reg [3:0] sync3_r;
  reg [3:0] pinFilt_r; // accepted level per pin
  reg [3:0] pinPrev_r; // last accepted level for edges

  // three flops, level accepted once stages two and three agree
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      pinFilt_r <= 4'h0;
      pinPrev_r <= 4'h0;
    end
    else if (clk_en)
    begin
      sync1_r <= {vBlankIn, hBlankIn, vsyncIn, hsyncIn};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // agreeing stages load the new level, disagreeing ones hold it
      pinFilt_r <= ((sync2_r ~^ sync3_r) & sync2_r) |
                   ((sync2_r ^ sync3_r) & pinFilt_r);
      pinPrev_r <= pinFilt_r;
    end
  end

  wire hsRise = pinFilt_r[0] & ~pinPrev_r[0];
  wire vsRise = pinFilt_r[1] & ~pinPrev_r[1];

  // ==========================================================
  // registers

  reg hvSel_r; // busy source select
  reg [6:0] hsDelay_r; // sync delay field
  reg [6:0] fieldAlign_r; // field align field
  reg [2:0] blankSel_r; // late, sync, early
  reg [1:0] irqStat_r;
  reg [1:0] irqMask_r;
  reg scrollRun_r;
  reg [7:0] fieldCnt_r; // fields left in a running scroll

  wire [15:0] regIdx = paddr[17:2];
  wire wrAcc = psel & penable & pwrite & clk_en;
  wire ctrlWr = wrAcc && (regIdx == `OSDSC_IDX_CTRL);

  // zero wait states, but frozen cycles stall the bus
  assign pready = clk_en;

  // write side of the register file
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hvSel_r <= 1'b0; // control word resets to all zero
      scrollAreaEnable <= 1'b0;
      hsDelay_r <= `OSDSC_RST_DLY;
      fieldAlign_r <= `OSDSC_RST_DLY;
      captionMode <= 1'b0; // general overlay mode after reset
      blankSel_r <= 3'h0;
      irqMask_r <= 2'h0;
    end
    else if (wrAcc)
    begin
      // only bits 6..4 of the control word have any effect
      if (regIdx == `OSDSC_IDX_CTRL)
      begin
        hvSel_r <= pwdata[`OSDSC_BIT_HV]; // (RL2) (RL1)
        scrollAreaEnable <= pwdata[`OSDSC_BIT_SCROLL_AREA_ENABLE]; // (RL3)
      end
      else if (regIdx == `OSDSC_IDX_HSD)
        hsDelay_r <= pwdata[6:0]; // (RL15)
      else if (regIdx == `OSDSC_IDX_FPA)
        fieldAlign_r <= pwdata[6:0]; // (RL15)
      else if (regIdx == `OSDSC_IDX_CONF)
      begin
        captionMode <= pwdata[`OSDSC_BIT_CAP]; // (RL11)
        blankSel_r <= pwdata[`OSDSC_BIT_LATE:`OSDSC_BIT_EARLY]; // (RL11)
      end
      else if (regIdx == `OSDSC_IDX_IRQM)
        irqMask_r <= pwdata[1:0];
    end
  end

  // read data is captured in the setup phase so it leaves a flop
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (clk_en && psel && !penable)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      if (regIdx == `OSDSC_IDX_CTRL)
        prdata <= 32'h0; // write only, reads zero
      else if (regIdx == `OSDSC_IDX_STAT)
        prdata <= {26'h0, busyFlag, scrollRun_r, firstScrollRow} << 2;
      else if (regIdx == `OSDSC_IDX_IRQS)
        prdata <= {30'h0, irqStat_r};
      else if (regIdx == `OSDSC_IDX_IRQM)
        prdata <= {30'h0, irqMask_r};
      else if (regIdx == `OSDSC_IDX_HSD)
        prdata <= {25'h0, hsDelay_r}; // (RL15)
      else if (regIdx == `OSDSC_IDX_FPA)
        prdata <= {25'h0, fieldAlign_r}; // (RL15)
      else if (regIdx == `OSDSC_IDX_CONF)
        prdata <= {24'h0, captionMode, blankSel_r, 4'h0};
      else
        pslverr <= 1'b1; // unmapped index
    end
  end

  // ==========================================================
  // scroll control

  reg scrollDone; // scroll finished by itself this cycle
  always @*
  begin
    scrollDone = scrollRun_r && vsRise && (fieldCnt_r == 8'h1);
  end

  // run flag, field count and first row; a write wins over completion
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scrollRun_r <= 1'b0;
      fieldCnt_r <= 8'h0;
      firstScrollRow <= 4'h0;
    end
    else if (clk_en)
    begin
      if (ctrlWr && pwdata[`OSDSC_BIT_RUN])
      begin
        scrollRun_r <= 1'b1; // (RL4)
        fieldCnt_r <= SCROLL_FIELDS[7:0];
      end
      else if (ctrlWr)
      begin
        // stop now as if all lines scrolled, or bump the row again
        scrollRun_r <= 1'b0; // (RL6)
        fieldCnt_r <= 8'h0;
        firstScrollRow <= firstScrollRow + 4'h1; // (RL6) (RL7)
      end
      else if (scrollRun_r && vsRise)
      begin
        fieldCnt_r <= fieldCnt_r - 8'h1;
        if (scrollDone)
        begin
          scrollRun_r <= 1'b0; // (RL5)
          firstScrollRow <= firstScrollRow + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // busy flag with lead time

  reg [31:0] elapsed_r; // clocks inside the current window
  reg [31:0] lastLen_r; // length of the previous window
  reg winPrev_r;
  wire inWin = hvSel_r ? pinFilt_r[3] : pinFilt_r[2]; // (RL2)
  // free only while a full lead time remains; unknown length keeps busy
  wire accessOk = inWin && ((elapsed_r + LEAD_CYC) < lastLen_r); // (RL14)

  // window timer; the length is learnt from the window before
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      elapsed_r <= 32'h0;
      lastLen_r <= 32'h0;
      winPrev_r <= 1'b0;
      busyFlag <= 1'b1;
    end
    else if (clk_en)
    begin
      winPrev_r <= inWin;
      busyFlag <= ~accessOk; // (RL14)
      if (inWin)
        elapsed_r <= elapsed_r + 32'h1;
      else
        elapsed_r <= 32'h0;
      if (winPrev_r && !inWin)
        lastLen_r <= elapsed_r;
    end
  end

  // ==========================================================
  // interrupts: sticky, write one to clear, set wins

  wire freeRise = accessOk & busyFlag;
  wire [1:0] irqSet = {freeRise, scrollDone};
  wire [1:0] irqClr = (wrAcc && regIdx == `OSDSC_IDX_IRQS) ?
                      pwdata[1:0] : 2'h0;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqStat_r <= 2'h0;
    else if (clk_en)
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
  end

  assign irq = |(irqStat_r & irqMask_r);

  // ==========================================================
  // delayed sync pulses

  reg [6:0] hsClamp; // delay held within the supported range
  always @*
  begin
    hsClamp = (hsDelay_r > `OSDSC_HSD_MAX) ? `OSDSC_HSD_MAX : hsDelay_r;
  end

  wire [10:0] hsLoad = dlyClks(hsClamp, `OSDSC_CHAR_CLKS); // (RL8) (RL9)
  wire [10:0] fpLoad = dlyClks(fieldAlign_r, `OSDSC_ALIGN_CLKS); // (RL10)

  reg [10:0] hsDly_r;
  reg [10:0] fpDly_r;
  reg [7:0] hsWid_r;
  reg [7:0] fpWid_r;
  reg hsPend_r;
  reg fpPend_r;

  // each hsync rising edge loads both delays, then a fixed width pulse follows;
  // a new edge during the wait restarts it rather than queueing
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hsDly_r <= 11'h0;
      fpDly_r <= 11'h0;
      hsWid_r <= 8'h0;
      fpWid_r <= 8'h0;
      hsPend_r <= 1'b0;
      fpPend_r <= 1'b0;
      hsyncOut <= 1'b0;
      halfLineFieldPulse <= 1'b0;
    end
    else if (clk_en)
    begin
      hsyncOut <= (hsWid_r != 8'h0);
      halfLineFieldPulse <= (fpWid_r != 8'h0);
      if (hsRise)
      begin
        hsDly_r <= hsLoad; // (RL8)
        hsPend_r <= 1'b1;
      end
      else if (hsPend_r && hsDly_r == 11'h0)
      begin
        hsPend_r <= 1'b0;
        hsWid_r <= PULSE_W[7:0];
      end
      else
      begin
        if (hsPend_r)
          hsDly_r <= hsDly_r - 11'h1;
        if (hsWid_r != 8'h0)
          hsWid_r <= hsWid_r - 8'h1;
      end
      if (hsRise)
      begin
        fpDly_r <= fpLoad; // (RL10)
        fpPend_r <= 1'b1;
      end
      else if (fpPend_r && fpDly_r == 11'h0)
      begin
        fpPend_r <= 1'b0;
        fpWid_r <= PULSE_W[7:0];
      end
      else
      begin
        if (fpPend_r)
          fpDly_r <= fpDly_r - 11'h1;
        if (fpWid_r != 8'h0)
          fpWid_r <= fpWid_r - 8'h1;
      end
    end
  end

  // ==========================================================
  // colour, fast blank and underline

  reg pixD1_r; // pixel active one clock ago
  reg pixD2_r; // pixel active two clocks ago
  reg [2:0] rgbD1_r; // colour one clock ago

  // colour leaves two clocks late so blank can lead it by one pixel
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pixD1_r <= 1'b0;
      pixD2_r <= 1'b0;
      rgbD1_r <= 3'h0;
      rgbOut <= 3'h0;
      fastBlank <= 1'b0;
      underlineEn <= 1'b1;
    end
    else if (clk_en)
    begin
      pixD1_r <= pixelOn;
      pixD2_r <= pixD1_r;
      rgbD1_r <= pixelRgb;
      rgbOut <= rgbD1_r; // (RL13)
      // all zero leaves blank off; set bits are ored together
      fastBlank <= (blankSel_r[0] & pixelOn) |
                   (blankSel_r[1] & pixD1_r) |
                   (blankSel_r[2] & pixD2_r); // (RL13)
      underlineEn <= ~(captionMode & serialAttr); // (RL12)
    end
  end

endmodule

// File: hw/osdsc_defines.vh
// constants for the overlay display scroll, sync and configuration block
// assumes a 200 MHz core clock and a 32-bit apb register bus
//
// Functional notes
// (RL1) control write bits 7,3..0 ignored
// (RL2) bit 6 picks horizontal or vertical busy
// (RL3) bit 5 enables scroll area
// (RL4) writing scroll run 1 starts scrolling
// (RL5) scroll busy clears itself on completion
// (RL6) writing 0 terminates scroll as finished
// (RL7) later 0 writes bump first row
// (RL8) hsync delay steps one full character
// (RL9) hsync delay spans 0 to 63 characters
// (RL10) field pulse delay steps twelve clocks
// (RL11) config holds caption mode and blank select
// (RL12) caption mode suppresses underline on attributes
// (RL13) blank select bits or early/sync/late pulses
// (RL14) busy low early by lead time
// (RL15) sync and align bit 7 reads zero
`ifndef OSDSC_DEFINES_VH
`define OSDSC_DEFINES_VH

// ==========================================================
// register indices, byte address is four times the index
`define OSDSC_IDX_CTRL 16'h87f8
`define OSDSC_IDX_STAT 16'h87f9
`define OSDSC_IDX_IRQS 16'h87fa
`define OSDSC_IDX_IRQM 16'h87fb
`define OSDSC_IDX_HSD 16'h87fc
`define OSDSC_IDX_FPA 16'h87fd
`define OSDSC_IDX_CONF 16'h87ff

// ==========================================================
// field positions
`define OSDSC_BIT_HV 6
`define OSDSC_BIT_SCROLL_AREA_ENABLE 5
`define OSDSC_BIT_RUN 4
`define OSDSC_BIT_CAP 7
`define OSDSC_BIT_LATE 6
`define OSDSC_BIT_SYNC 5
`define OSDSC_BIT_EARLY 4
`define OSDSC_IRQ_DONE 0
`define OSDSC_IRQ_FREE 1

// ==========================================================
// reset values
`define OSDSC_RST_CTRL 8'h00
`define OSDSC_RST_DLY 7'h00
`define OSDSC_RST_CONF 8'h00

// ==========================================================
// timing
`define OSDSC_CLK_MHZ 200
`define OSDSC_LEAD_MS 4
`define OSDSC_CHAR_CLKS 4'd12
`define OSDSC_ALIGN_CLKS 4'd12
`define OSDSC_HSD_MAX 7'd63

`endif

// File: hw/unused_placeholder_none.v
`timescale 1ns/1ps

// File: testbench/osdsc_core_asserts.sv
// port checker for the overlay scroll, sync and config block
// assumes clk_en held high, so every access answers at once
`timescale 1ns/1ps
`include "osdsc_defines.vh"
module osdsc_core_asserts #(
  parameter PULSE_W = 8
)
(
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire pixelOn,
  input wire serialAttr,
  input wire hsyncOut,
  input wire halfLineFieldPulse,
  input wire fastBlank,
  input wire underlineEn,
  input wire captionMode,
  input wire scrollAreaEnable,
  input wire [3:0] firstScrollRow
);
  // ====
  // helpers: decoded accesses and a shadow of the config byte
  logic [7:0] cf_r;
  wire acc = psel && penable;
  wire rdAcc = acc && !pwrite;
  wire wrCtrl = acc && pwrite && paddr[17:2] == `OSDSC_IDX_CTRL;
  wire wrConf = acc && pwrite && paddr[17:2] == `OSDSC_IDX_CONF;
  // 0x87fe is the only hole in the index window
  wire mapped = paddr[17:5] == 13'h10ff && paddr[4:2] != 3'h6;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cf_r <= 8'h00;
    else if (wrConf)
      cf_r <= pwdata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a pulse is exactly eight cycles high, then low
  sequence sPulse8(s);
    s[*8] ##1 !s;
  endsequence
  // ====
  // assertions
  a_hs_width: assert property ($rose(hsyncOut) |-> sPulse8(hsyncOut))
    else $error("hsync pulse width wrong");
  a_field_width: assert property ($rose(halfLineFieldPulse)
    |-> sPulse8(halfLineFieldPulse)) else $error("field pulse width wrong");
  a_ctrl_reads_zero: assert property (rdAcc
    && paddr[17:2] == `OSDSC_IDX_CTRL |-> prdata == 32'h0)
    else $error("control register read not zero");
  a_rsv_bit_zero: assert property (rdAcc && paddr[17:3] == 15'h43fe
    |-> prdata[31:7] == 25'h0) else $error("reserved bits not zero");
  a_slverr_map: assert property (acc |-> pslverr == !mapped)
    else $error("slave error does not match map");
  a_row_bump: assert property (wrCtrl && !pwdata[4]
    |=> firstScrollRow == $past(firstScrollRow) + 4'h1)
    else $error("first row did not advance");
  a_scroll_area_enable_follow: assert property (wrCtrl
    |=> scrollAreaEnable == $past(pwdata[5])) else $error("scroll enable");
  a_cap_follow: assert property (wrConf
    |=> captionMode == $past(pwdata[7])) else $error("caption mode");
  a_underline_cut: assert property (captionMode && serialAttr
    |=> !underlineEn) else $error("underline not suppressed");
  a_fb_timing: assert property (fastBlank ==
    ($past(cf_r[4]) && $past(pixelOn) || $past(cf_r[5]) && $past(pixelOn, 2)
    || $past(cf_r[6]) && $past(pixelOn, 3))) else $error("fast blank timing");
endmodule
bind osdsc_core osdsc_core_asserts #(.PULSE_W(PULSE_W)) u_osdsc_core_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .pixelOn(pixelOn), .serialAttr(serialAttr),
  .hsyncOut(hsyncOut), .halfLineFieldPulse(halfLineFieldPulse),
  .fastBlank(fastBlank), .underlineEn(underlineEn),
  .captionMode(captionMode), .scrollAreaEnable(scrollAreaEnable),
  .firstScrollRow(firstScrollRow));

// File: testbench/osdsc_video_sink.sv
// video sink model: keys overlay colour in while fast blank is high
// assumes rgb and fast blank arrive registered on core_clk
`timescale 1ns/1ps
module osdsc_video_sink (
  input wire logic core_clk,
  input wire logic [2:0] rgbOut,
  input wire logic fastBlank,
  output int fbCount,
  output int keyCount
);
  // ====
  // keyer: counts keyed pixels so the bench can judge blank width
  initial fbCount = 0;
  initial keyCount = 0;
  always @(posedge core_clk)
  begin
    if (fastBlank === 1'b1)
      fbCount <= fbCount + 1;
    // blank and colour together: the keyer shows overlay colour
    if (fastBlank === 1'b1 && rgbOut !== 3'h0)
      keyCount <= keyCount + 1;
  end
endmodule

// File: testbench/tb_osdsc_core.sv
// top bench for the overlay scroll, sync and configuration block
// assumes short sim counts: lead 20 cycles, scroll of 2 fields
`timescale 1ns/1ps
`include "osdsc_defines.vh"
module tb_osdsc_core;
  // ====
  // stimulus, observed outputs and bookkeeping
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic hsyncIn = 0, vsyncIn = 0, hBlankIn = 0, vBlankIn = 0;
  logic pixelOn = 0, serialAttr = 0, e;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [2:0] pixelRgb = 0, rgbOut;
  logic pready, pslverr, hsyncOut, halfLineFieldPulse, fastBlank;
  logic underlineEn, captionMode, scrollAreaEnable, busyFlag, irq;
  logic [3:0] firstScrollRow;
  int bad_count = 0, checks = 0, fbCount, n, a0, a1, a2, a3, b0, b1;
  int keyCount, m;
  logic clkEn = 1;
  localparam logic [31:0] ALL = 32'hffffffff;
  always #2.5 core_clk = ~core_clk;
  // clk_en stays high except for one short freeze at the end
  osdsc_core #(.LEAD_CYC(20), .SCROLL_FIELDS(2)) u_osdsc_core (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .hBlankIn(hBlankIn),
    .vBlankIn(vBlankIn), .pixelOn(pixelOn), .pixelRgb(pixelRgb),
    .serialAttr(serialAttr), .hsyncOut(hsyncOut),
    .halfLineFieldPulse(halfLineFieldPulse), .rgbOut(rgbOut),
    .fastBlank(fastBlank), .underlineEn(underlineEn),
    .captionMode(captionMode), .scrollAreaEnable(scrollAreaEnable),
    .firstScrollRow(firstScrollRow), .busyFlag(busyFlag), .irq(irq));
  osdsc_video_sink u_osdsc_video_sink (.core_clk(core_clk),
    .rgbOut(rgbOut), .fastBlank(fastBlank), .fbCount(fbCount),
    .keyCount(keyCount));
  // ====
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // one apb transfer; the idle edge first keeps strobes single-driven
  task automatic apb(input logic [15:0] idx, input logic w,
    input logic [7:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      bad_count++;
      wrap_up();
    end
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] m, exp);
    apb(i, 0, 8'h00);
    chk(r & m, exp);
  endtask
  // one hsync edge; cycles until each delayed pulse rises
  task automatic hs(output int a, output int b);
    a = -1;
    b = -1;
    hsyncIn <= 1;
    for (int i = 0; i < 900; i++)
    begin
      @(posedge core_clk);
      if (hsyncOut === 1'b1 && a < 0)
        a = i;
      if (halfLineFieldPulse === 1'b1 && b < 0)
        b = i;
    end
    hsyncIn <= 0;
  endtask
  // one blank window of len cycles; counts cycles of access allowed
  task automatic win(input logic v, input int len, output int lo);
    lo = 0;
    hBlankIn <= !v;
    vBlankIn <= v;
    repeat (len)
    begin
      @(posedge core_clk);
      lo += (busyFlag === 1'b0);
    end
    e = busyFlag;
    hBlankIn <= 0;
    vBlankIn <= 0;
    tk(40);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ====
  // watchdog: the whole run needs well under 20000 cycles
  initial
  begin
    tk(40000);
    bad_count++;
    wrap_up();
  end
  // ====
  // test sequence
  initial
  begin
    tk(12);
    rst_n <= 1;
    rd(`OSDSC_IDX_HSD, ALL, 32'h0);
    apb(`OSDSC_IDX_HSD, 1, 8'hff);
    rd(`OSDSC_IDX_HSD, ALL, 32'h7f);
    apb(`OSDSC_IDX_FPA, 1, 8'hff);
    rd(`OSDSC_IDX_FPA, ALL, 32'h7f);
    apb(`OSDSC_IDX_CONF, 1, 8'hff);
    rd(`OSDSC_IDX_CONF, ALL, 32'hf0);
    chk(captionMode, 1);
    serialAttr <= 1;
    tk(3);
    chk(underlineEn, 0);
    serialAttr <= 0;
    apb(`OSDSC_IDX_CONF, 1, 8'h00);
    // ignored bits only; the cleared run bit still advances the row
    apb(`OSDSC_IDX_CTRL, 1, 8'h8f);
    rd(`OSDSC_IDX_CTRL, ALL, 32'h0);
    chk(scrollAreaEnable, 0);
    chk(firstScrollRow, 1);
    rd(16'h87fe, ALL, 32'h0);
    chk(pslverr, 1);
    $display("register test done");
    apb(`OSDSC_IDX_CTRL, 1, 8'h10);
    rd(`OSDSC_IDX_STAT, 32'h40, 32'h40);
    repeat (2)
    begin
      vsyncIn <= 1;
      tk(8);
      vsyncIn <= 0;
      tk(8);
    end
    rd(`OSDSC_IDX_STAT, 32'h7c, 32'h08);
    chk(irq, 0);
    apb(`OSDSC_IDX_IRQM, 1, 8'h01);
    tk(1);
    chk(irq, 1);
    apb(`OSDSC_IDX_IRQS, 1, 8'h01);
    tk(1);
    chk(irq, 0);
    apb(`OSDSC_IDX_CTRL, 1, 8'h30);
    tk(1);
    chk(scrollAreaEnable, 1);
    apb(`OSDSC_IDX_CTRL, 1, 8'h00);
    rd(`OSDSC_IDX_STAT, 32'h7c, 32'h0c);
    apb(`OSDSC_IDX_CTRL, 1, 8'h00);
    tk(1);
    chk(firstScrollRow, 4);
    chk(scrollAreaEnable, 0);
    $display("scroll test done");
    apb(`OSDSC_IDX_HSD, 1, 8'h00);
    apb(`OSDSC_IDX_FPA, 1, 8'h00);
    hs(a0, b0);
    apb(`OSDSC_IDX_HSD, 1, 8'h02);
    apb(`OSDSC_IDX_FPA, 1, 8'h01);
    hs(a1, b1);
    chk(a1 - a0, 24);
    chk(b1 - b0, 12);
    apb(`OSDSC_IDX_HSD, 1, 8'd63);
    hs(a2, b1);
    chk(a2 - a0, 756);
    apb(`OSDSC_IDX_HSD, 1, 8'd100);
    hs(a3, b1);
    chk(a3, a2);
    $display("sync test done");
    for (int c = 0; c < 8; c++)
    begin
      apb(`OSDSC_IDX_CONF, 1, {1'b0, c[2:0], 4'h0});
      n = fbCount;
      m = keyCount;
      pixelOn <= 1;
      pixelRgb <= 3'h7;
      tk(1);
      pixelOn <= 0;
      pixelRgb <= 3'h0;
      tk(6);
      chk(fbCount - n, $countones(c));
      chk(keyCount - m, c[1]);
    end
    $display("blank test done");
    win(0, 100, n);
    win(0, 100, n);
    chk(n > 50, 1);
    chk(e, 1);
    rd(`OSDSC_IDX_IRQS, 32'h2, 32'h2);
    win(1, 100, n);
    win(1, 100, n);
    chk(n, 0);
    apb(`OSDSC_IDX_CTRL, 1, 8'h40);
    win(1, 100, n);
    win(1, 100, n);
    chk(n > 50, 1);
    $display("busy test done");
    clkEn <= 0;
    tk(2);
    chk(pready, 0);
    clkEn <= 1;
    tk(1);
    $display("freeze test done");
    wrap_up();
  end
endmodule
